// [src/status_fault_reporting.sv]
// status words, poll byte, error code and self-test report
// assumes one-cycle command strobes from a command decoder
//
// Function
// - four twelve-bit words share one bit layout, bit 11 highest
// - bits 0, 1, 9 follow voltage, positive and negative current regulation
// - bit 2 set while output is unregulated
// - bits 3, 4, 6 flag voltage, thermal and current trips
// - bit 5 flags an open sense lead
// - bit 7 set on programming error, cleared by error query only
// - bit 8 set while external shutdown holds output off
// - bit 10 fast mode, bit 11 normal mode on dual-mode variants
// - enable mask written as weight sum gates fault bits
// - mask value out of limits rejected with code 46
// - poll bit 0 while fault word nonzero, cleared by fault read
// - poll bit 1 set at power-on, cleared by clear command
// - poll bit 4 low while busy, high when done
// - poll bit 5 follows the pending error, one cycle ahead of condition bit 7
// - poll bit 6 set on service request, cleared by serial poll
// - self-test query returns failure result, five digits
// - parser codes 10, 11, 20, 21, 22
// - parser codes 30 comma, 31 terminator
// - code 8 when talked without query
// - second power-on service setting gives code 2
// - without relay option codes 4 and 5
// - limit codes 41 to 45
// - codes 1 and 51 for memory faults, 0 none pending
// - service requests for enabled faults when enabled, off at init
`timescale 1ns/1ps
`include "status_fault_defs.svh"

module status_fault_reporting
   import status_fault_pkg::*;
#(
   parameter int WORD_W = 12,
   parameter int TEST_W = 17,
   parameter bit DUAL_MODE = 1'b1,
   parameter bit RELAY_FITTED = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire supply_state_t supply_state,
   input wire parse_event_t parse_event,
   input wire command_t command,
   input wire logic [15:0] command_value,
   input wire logic busy,
   input wire logic [TEST_W-1:0] test_failures,
   input wire logic test_finished,
   output logic [11:0] condition_status_word,
   output logic [11:0] accumulated_condition_word,
   output logic [11:0] masked_condition_word,
   output logic [11:0] condition_enable_word,
   output logic [7:0] poll_summary_byte,
   output logic [7:0] error_code,
   output logic [TEST_W-1:0] test_result,
   output logic test_start,
   output logic test_valid,
   output logic service_request
);

   // ==========================================
   // parameter checks
   if (WORD_W != 12) begin : g_bad_word
      $error("word width must be 12");
   end
   if (TEST_W < 1 || TEST_W > 17) begin : g_bad_test
      $error("test result width out of range");
   end

   // ==========================================
   // live condition vector
   function automatic logic [11:0] live_conditions(input supply_state_t s, input logic err, input bit dual);
      logic [11:0] c;
      c = `COND_RESET;
      c[`COND_VOLT_BIT] = s.constant_voltage_state;
      c[`COND_PCC_BIT] = s.positive_current_limit_state;
      c[`COND_NCC_BIT] = s.negative_current_limit_state;
      c[`COND_UNREG_BIT] = s.unregulated;
      c[`COND_HVT_BIT] = s.high_voltage_trip;
      c[`COND_THERM_BIT] = s.thermal_trip;
      c[`COND_HCT_BIT] = s.high_current_trip;
      c[`COND_SENSE_BIT] = s.sense_lead_open;
      c[`COND_ERROR_BIT] = err;
      c[`COND_SHUT_BIT] = s.external_shutdown;
      c[`COND_FAST_BIT] = dual & s.fast_response_mode;
      c[`COND_STD_BIT] = dual & s.standard_response_mode;
      return c;
   endfunction : live_conditions

   logic error_pending;
   logic [11:0] next_condition;
   logic new_error;
   logic [7:0] next_error_code;
   logic power_request_seen;
   logic service_request_enable;
   logic fault_any;
   logic [11:0] fault_set;
   logic mask_bad;
   logic [TEST_W-1:0] fail_latched;
   test_state_t test_state;
   logic masked_condition_summary;
   logic power_up_seen;
   logic ready_flag;
   logic error_flag;
   logic service_request_flag;

   assign next_condition = live_conditions(supply_state, error_pending, DUAL_MODE);
   assign mask_bad = command.condition_enable_write && (command_value > `ENABLE_MAX);

   // ==========================================
   // error code selection
   always_comb begin
      next_error_code = `ERR_NONE;
      if (parse_event.header_expected) next_error_code = `ERR_HEADER_EXP;
      else if (parse_event.bad_header) next_error_code = `ERR_BAD_HEADER;
      else if (parse_event.number_expected) next_error_code = `ERR_NUM_EXP;
      else if (parse_event.number_syntax) next_error_code = `ERR_NUM_SYNTAX;
      else if (parse_event.number_range) next_error_code = `ERR_NUM_RANGE;
      else if (parse_event.comma_missing) next_error_code = `ERR_COMMA;
      else if (parse_event.term_missing) next_error_code = `ERR_TERM;
      else if (parse_event.param_limit) next_error_code = `ERR_PARAM;
      else if (parse_event.volt_limit) next_error_code = `ERR_VOLT;
      else if (parse_event.curr_limit) next_error_code = `ERR_CURR;
      else if (parse_event.hvset_limit) next_error_code = `ERR_HVSET;
      else if (parse_event.delay_limit) next_error_code = `ERR_DELAY;
      else if (mask_bad) next_error_code = `ERR_MASK;
      else if (parse_event.nv_write_fail) next_error_code = `ERR_NV_WRITE;
      else if (parse_event.nv_sum_fail) next_error_code = `ERR_NV_SUM;
      else if (parse_event.talk_no_query) next_error_code = `ERR_NOTHING_TO_SAY;
      else if (command.power_request_write && power_request_seen) next_error_code = `ERR_SECOND_PWR_REQ;
      else if (!RELAY_FITTED && command.relay_power_on_setting) next_error_code = `ERR_NO_RELAY_PWR;
      else if (!RELAY_FITTED && command.relay_command) next_error_code = `ERR_NO_RELAY;
   end
   assign new_error = (next_error_code != `ERR_NONE);

   // ==========================================
   // error code and error bit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         error_code <= `ERR_NONE;
      end else if (new_error) begin
         error_code <= next_error_code;
      end else if (command.error_query) begin
         error_code <= `ERR_NONE;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         error_pending <= 1'b0;
      end else if (new_error) begin
         error_pending <= 1'b1;
      end else if (command.error_query) begin
         error_pending <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_request_seen <= 1'b0;
      end else if (command.power_request_write) begin
         power_request_seen <= 1'b1;
      end
   end

   // ==========================================
   // condition and accumulated words
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         condition_status_word <= `COND_RESET;
      end else begin
         condition_status_word <= next_condition;
      end
   end

   // sticky copy of every condition seen
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         accumulated_condition_word <= `COND_RESET;
      end else begin
         accumulated_condition_word <= accumulated_condition_word | next_condition;
      end
   end

   // ==========================================
   // enable mask
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         condition_enable_word <= `ENABLE_RESET;
      end else if (command.condition_enable_write) begin
         if (!mask_bad) condition_enable_word <= command_value[11:0];
      end
   end

   // ==========================================
   // fault word
   // enabled conditions only
   assign fault_set = next_condition & condition_enable_word;
   generate
      for (genvar i = 0; i < WORD_W; i++) begin : g_fault
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               masked_condition_word[i] <= 1'b0;
            end else if (fault_set[i]) begin
               masked_condition_word[i] <= 1'b1;
            end else if (command.fault_read) begin
               masked_condition_word[i] <= 1'b0;
            end
         end
      end
   endgenerate
   assign fault_any = |fault_set || (|masked_condition_word && !command.fault_read);

   // ==========================================
   // service request enable
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         service_request_enable <= 1'b0;
      end else if (command.service_request_write) begin
         service_request_enable <= command_value[0];
      end
   end

   // ==========================================
   // poll summary byte
   // fault summary
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         masked_condition_summary <= 1'b0;
      end else begin
         masked_condition_summary <= fault_any;
      end
   end

   // set at power-on, clear command clears
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_up_seen <= 1'b1;
      end else if (command.clear_command) begin
         power_up_seen <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ready_flag <= 1'b0;
      end else begin
         ready_flag <= !busy;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         error_flag <= 1'b0;
      end else begin
         error_flag <= new_error || (error_pending && !command.error_query);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         service_request_flag <= 1'b0;
      end else if (service_request_enable && |fault_set) begin
         service_request_flag <= 1'b1;
      end else if (command.serial_poll) begin
         service_request_flag <= 1'b0;
      end
   end

   // unused poll bits read as zero
   always_comb begin
      poll_summary_byte = `POLL_RESET;
      poll_summary_byte[`POLL_FAULT_BIT] = masked_condition_summary;
      poll_summary_byte[`POLL_PWR_BIT] = power_up_seen;
      poll_summary_byte[`POLL_READY_BIT] = ready_flag;
      poll_summary_byte[`POLL_ERROR_BIT] = error_flag;
      poll_summary_byte[`POLL_SVC_BIT] = service_request_flag;
   end
   assign service_request = service_request_flag;

   // ==========================================
   // self-test sequencer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         test_state <= TEST_IDLE;
      end else begin
         case (test_state)
            TEST_IDLE: begin
               if (command.self_test) test_state <= TEST_RUN;
            end
            TEST_RUN: begin
               if (test_finished) test_state <= TEST_DONE;
            end
            // a new query right after a result starts at once
            TEST_DONE: begin
               if (command.self_test) test_state <= TEST_RUN;
               else test_state <= TEST_IDLE;
            end
            default: test_state <= TEST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fail_latched <= '0;
      end else if (test_state == TEST_RUN) begin
         fail_latched <= fail_latched | test_failures;
      end else begin
         fail_latched <= '0;
      end
   end

   // result held until the next run ends
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         test_result <= '0;
      end else if (test_state == TEST_RUN && test_finished) begin
         test_result <= fail_latched | test_failures;
      end
   end
   assign test_start = (test_state == TEST_RUN);
   assign test_valid = (test_state == TEST_DONE);

endmodule : status_fault_reporting

// [common/status_fault_defs.svh]
// constants for the status and fault reporting block
// assumes inclusion by the design file
`ifndef STATUS_FAULT_DEFS_SVH
`define STATUS_FAULT_DEFS_SVH

// ==========================================
// condition word bit positions
`define COND_VOLT_BIT 0
`define COND_PCC_BIT 1
`define COND_UNREG_BIT 2
`define COND_HVT_BIT 3
`define COND_THERM_BIT 4
`define COND_SENSE_BIT 5
`define COND_HCT_BIT 6
`define COND_ERROR_BIT 7
`define COND_SHUT_BIT 8
`define COND_NCC_BIT 9
`define COND_FAST_BIT 10
`define COND_STD_BIT 11

// ==========================================
// poll byte bit positions
`define POLL_FAULT_BIT 0
`define POLL_PWR_BIT 1
`define POLL_READY_BIT 4
`define POLL_ERROR_BIT 5
`define POLL_SVC_BIT 6

// ==========================================
// reset values and limits
`define COND_RESET 12'h000
`define ENABLE_RESET 12'h000
`define POLL_RESET 8'h00
`define ENABLE_MAX 16'h0fff

// ==========================================
// error codes
`define ERR_NONE 8'h00
`define ERR_NV_WRITE 8'h01
`define ERR_SECOND_PWR_REQ 8'h02
`define ERR_NO_RELAY_PWR 8'h04
`define ERR_NO_RELAY 8'h05
`define ERR_NOTHING_TO_SAY 8'h08
`define ERR_HEADER_EXP 8'h0a
`define ERR_BAD_HEADER 8'h0b
`define ERR_NUM_EXP 8'h14
`define ERR_NUM_SYNTAX 8'h15
`define ERR_NUM_RANGE 8'h16
`define ERR_COMMA 8'h1e
`define ERR_TERM 8'h1f
`define ERR_PARAM 8'h29
`define ERR_VOLT 8'h2a
`define ERR_CURR 8'h2b
`define ERR_HVSET 8'h2c
`define ERR_DELAY 8'h2d
`define ERR_MASK 8'h2e
`define ERR_NV_SUM 8'h33

`endif

// [common/status_fault_pkg.sv]
// types for the status and fault reporting block
// assumes the defs header is on the include path
package status_fault_pkg;

   // ==========================================
   // live inputs from regulation and protection
   typedef struct packed {
      logic constant_voltage_state;
      logic positive_current_limit_state;
      logic negative_current_limit_state;
      logic unregulated;
      logic high_voltage_trip;
      logic thermal_trip;
      logic high_current_trip;
      logic sense_lead_open;
      logic external_shutdown;
      logic fast_response_mode;
      logic standard_response_mode;
   } supply_state_t;

   // ==========================================
   // one-cycle parser and checker events
   typedef struct packed {
      logic header_expected;
      logic bad_header;
      logic number_expected;
      logic number_syntax;
      logic number_range;
      logic comma_missing;
      logic term_missing;
      logic param_limit;
      logic volt_limit;
      logic curr_limit;
      logic hvset_limit;
      logic delay_limit;
      logic nv_write_fail;
      logic nv_sum_fail;
      logic talk_no_query;
   } parse_event_t;

   // ==========================================
   // one-cycle command strobes
   typedef struct packed {
      logic condition_enable_write;
      logic clear_command;
      logic error_query;
      logic fault_read;
      logic serial_poll;
      logic power_request_write;
      logic relay_power_on_setting;
      logic relay_command;
      logic service_request_write;
      logic self_test;
   } command_t;

   typedef enum logic [2:0] {
      TEST_IDLE = 3'b001,
      TEST_RUN = 3'b010,
      TEST_DONE = 3'b100
   } test_state_t;

endpackage : status_fault_pkg

// [sim/status_fault_reporting_properties.sv]
// assertions on the status and fault block ports
// assumes binding into status_fault_reporting
`timescale 1ns/1ps
module status_fault_reporting_properties
   import status_fault_pkg::*;
#(
   parameter int TEST_W = 17
) (
   input wire logic clk,
   input wire logic rst,
   input wire supply_state_t supply_state,
   input wire parse_event_t parse_event,
   input wire command_t command,
   input wire logic [15:0] command_value,
   input wire logic busy,
   input wire logic [TEST_W-1:0] test_failures,
   input wire logic test_finished,
   input wire logic [11:0] condition_status_word,
   input wire logic [11:0] accumulated_condition_word,
   input wire logic [11:0] masked_condition_word,
   input wire logic [11:0] condition_enable_word,
   input wire logic [7:0] poll_summary_byte,
   input wire logic [7:0] error_code,
   input wire logic [TEST_W-1:0] test_result,
   input wire logic test_start,
   input wire logic test_valid,
   input wire logic service_request
);
   // ==========================================
   // helpers
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [11:0] live;
   logic quiet;
   assign live = {supply_state.standard_response_mode, supply_state.fast_response_mode,
      supply_state.negative_current_limit_state, supply_state.external_shutdown, 1'b0,
      supply_state.high_current_trip, supply_state.sense_lead_open, supply_state.thermal_trip,
      supply_state.high_voltage_trip, supply_state.unregulated,
      supply_state.positive_current_limit_state, supply_state.constant_voltage_state};
   assign quiet = parse_event == '0 && !command.condition_enable_write && !command.power_request_write
      && !command.relay_power_on_setting && !command.relay_command;
   // ==========================================
   // properties
   a_live_map: assert property (!$past(rst) |-> (condition_status_word & 12'hf7f) == $past(live))
      else $error("condition word off live state");
   a_err_set: assert property (|parse_event |=> poll_summary_byte[5] && error_code != 8'h00
      ##1 condition_status_word[7])
      else $error("error did not flag");
   a_err_clear: assert property (command.error_query && quiet |=> error_code == 8'h00 &&
      !poll_summary_byte[5] ##1 !condition_status_word[7])
      else $error("error query did not clear");
   a_mask_write: assert property (command.condition_enable_write && command_value <= 16'h0fff
      |=> condition_enable_word == $past(command_value[11:0]))
      else $error("mask not written");
   a_mask_reject: assert property (command.condition_enable_write && command_value > 16'h0fff &&
      parse_event == '0 |=> error_code == 8'h2e && $stable(condition_enable_word))
      else $error("bad mask not refused");
   a_fault_latch: assert property (1'b1 |=> (masked_condition_word & $past(live & condition_enable_word))
      == $past(live & condition_enable_word))
      else $error("fault bit not latched");
   a_fault_clear: assert property (command.fault_read && (live & condition_enable_word) == 12'h000 &&
      !condition_enable_word[7] |=> masked_condition_word == 12'h000)
      else $error("fault read did not clear");
   a_ready_busy: assert property (!$past(rst) |-> poll_summary_byte[4] == !$past(busy))
      else $error("ready bit wrong");
   a_request_mirror: assert property (service_request == poll_summary_byte[6] && poll_summary_byte[7] == 1'b0 &&
      poll_summary_byte[3:2] == 2'b00)
      else $error("service request or unused poll bits wrong");
   a_power_clear: assert property (command.clear_command |=> !poll_summary_byte[1])
      else $error("power bit not cleared");
   a_test_start: assert property (command.self_test && !test_start |=> test_start)
      else $error("self test did not start");
endmodule : status_fault_reporting_properties

bind status_fault_reporting status_fault_reporting_properties #(.TEST_W(TEST_W)) props_inst (.*);

// [sim/remote_controller.sv]
// remote controller model issuing command strobes
// assumes the bench calls issue after a clock edge
`timescale 1ns/1ps
module remote_controller
   import status_fault_pkg::*;
(
   input wire logic clk,
   output command_t command,
   output logic [15:0] command_value
);
   initial begin
      command = '0;
      command_value = 16'h0000;
   end
   task automatic issue(input command_t c, input logic [15:0] v);
      @(posedge clk);
      command <= c;
      command_value <= v;
      @(posedge clk);
      command <= '0;
   endtask : issue
endmodule : remote_controller

// [sim/status_fault_reporting_bench.sv]
// self-checking bench for the status and fault block
// assumes package, checker and controller model compiled first
`timescale 1ns/1ps
module status_fault_reporting_bench import status_fault_pkg::*;;
   localparam int EN = 9, CLEAR = 8, QRY = 7, FRD = 6, SPL = 5, PSRQ = 4, RPON = 3, RLY = 2, SVC = 1, TST = 0;
   logic clk = 1'b0;
   logic rst = 1'b1;
   supply_state_t supply_state = '0;
   parse_event_t parse_event = '0;
   command_t command;
   logic [15:0] command_value;
   logic busy = 1'b0;
   logic [16:0] test_failures = 17'h00000;
   logic test_finished = 1'b0;
   logic [11:0] cond, acc, fault, mask;
   logic [7:0] poll, err;
   logic [16:0] test_result;
   logic test_start, test_valid, svc_req;
   int mismatches = 0;
   int compares = 0;
   always #12.5 clk = ~clk;
   status_fault_reporting status_fault_reporting_inst (.clk(clk), .rst(rst), .supply_state(supply_state),
      .parse_event(parse_event), .command(command), .command_value(command_value), .busy(busy),
      .test_failures(test_failures), .test_finished(test_finished), .condition_status_word(cond),
      .accumulated_condition_word(acc), .masked_condition_word(fault), .condition_enable_word(mask),
      .poll_summary_byte(poll), .error_code(err), .test_result(test_result), .test_start(test_start),
      .test_valid(test_valid), .service_request(svc_req));
   remote_controller remote_controller_inst (.clk(clk), .command(command), .command_value(command_value));
   // ==========================================
   // shared tasks
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick
   task automatic cmd(input int b, input logic [15:0] v);
      remote_controller_inst.issue(command_t'(10'h001 << b), v);
      #1;
   endtask : cmd
   task automatic pev(input int b);
      @(posedge clk);
      parse_event <= parse_event_t'(15'h0001 << b);
      @(posedge clk);
      parse_event <= '0;
      #1;
   endtask : pev
   task automatic sup(input logic [10:0] s);
      @(posedge clk);
      supply_state <= supply_state_t'(s);
      repeat (2) @(posedge clk);
      #1;
   endtask : sup
   task automatic stop_test;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test
   // ==========================================
   // scenarios
   task automatic t_reset;
      chk(poll, 17'h12);
      chk(cond, 17'h0);
      chk(err, 17'h0);
   endtask : t_reset
   task automatic t_cond;
      int map [11] = '{0, 1, 9, 2, 3, 4, 6, 5, 8, 10, 11};
      for (int j = 0; j < 11; j++) begin
         sup(11'h400 >> j);
         chk(cond, 17'(12'h001 << map[j]));
      end
      sup(11'h000);
      chk(acc, 17'hf7f);
      chk(fault, 17'h0);
   endtask : t_cond
   task automatic t_fault;
      cmd(EN, 16'h0048);
      chk(mask, 17'h048);
      sup(11'h040);
      sup(11'h200);
      chk(fault, 17'h008);
      chk(poll[0], 1);
      cmd(FRD, 16'h0);
      chk(fault, 17'h0);
      tick;
      chk(poll[0], 0);
      sup(11'h000);
   endtask : t_fault
   task automatic t_mask;
      cmd(EN, 16'h1000);
      chk(err, 17'h2e);
      chk(mask, 17'h048);
      cmd(EN, 16'h0fff);
      chk(mask, 17'hfff);
      cmd(EN, 16'h0000);
   endtask : t_mask
   task automatic t_errors;
      logic [7:0] code [15] = '{8'h0a, 8'h0b, 8'h14, 8'h15, 8'h16, 8'h1e, 8'h1f, 8'h29, 8'h2a, 8'h2b,
         8'h2c, 8'h2d, 8'h01, 8'h33, 8'h08};
      for (int i = 0; i < 15; i++) begin
         pev(14 - i);
         chk(err, code[i]);
         chk(poll[5], 1);
      end
      tick;
      chk(cond[7], 1);
      cmd(QRY, 16'h0);
      chk(err, 17'h0);
      chk(poll[5], 0);
      tick;
      chk(cond[7], 0);
   endtask : t_errors
   task automatic t_cmds;
      cmd(PSRQ, 16'h0001);
      chk(err, 17'h0);
      cmd(PSRQ, 16'h0001);
      chk(err, 17'h02);
      cmd(RPON, 16'h0001);
      chk(err, 17'h04);
      cmd(RLY, 16'h0001);
      chk(err, 17'h05);
      cmd(QRY, 16'h0);
      chk(poll[1], 1);
      cmd(CLEAR, 16'h0);
      chk(poll[1], 0);
   endtask : t_cmds
   task automatic t_busy;
      @(posedge clk);
      busy <= 1'b1;
      tick;
      chk(poll[4], 0);
      @(posedge clk);
      busy <= 1'b0;
      tick;
      chk(poll[4], 1);
   endtask : t_busy
   task automatic t_service;
      cmd(EN, 16'h0001);
      sup(11'h400);
      chk(svc_req, 0);
      cmd(SVC, 16'h0001);
      tick;
      chk(poll[6], 1);
      chk(svc_req, 1);
      sup(11'h000);
      cmd(SPL, 16'h0);
      chk(poll[6], 0);
      cmd(FRD, 16'h0);
      cmd(SVC, 16'h0);
      cmd(EN, 16'h0);
   endtask : t_service
   task automatic t_self;
      cmd(TST, 16'h0);
      chk(test_start, 1);
      @(posedge clk);
      test_failures <= 17'h00015;
      test_finished <= 1'b1;
      @(posedge clk);
      test_failures <= 17'h00000;
      test_finished <= 1'b0;
      #1;
      for (int k = 0; k < 8 && test_valid !== 1'b1; k++) tick;
      chk(test_valid, 1);
      chk(test_result, 17'h00015);
   endtask : t_self
   // ==========================================
   // main sequence and watchdog
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      t_reset;
      t_cond;
      t_fault;
      t_mask;
      t_errors;
      t_cmds;
      t_busy;
      t_service;
      t_self;
      stop_test;
   end
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      stop_test;
   end
endmodule : status_fault_reporting_bench
